// ---- src/timer_consts.svh ----
// Register offsets, field positions, reset values and fixed readback codes
// Assumes inclusion by bare name from files under src/
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH
// Byte offsets on the register bus
`define OFS_CTRL 8'h00
`define OFS_A_COUNT 8'h04
`define OFS_B_COUNT 8'h08
`define OFS_IRQ_STAT 8'h0C
`define OFS_IRQ_MASK 8'h10
`define OFS_STATUS 8'h14
// Control register fields
`define CTRL_A_START 0
`define CTRL_A_MODE 2:1
`define CTRL_A_UP 3
`define CTRL_B_START 4
`define CTRL_B_MODE 6:5
`define CTRL_B_WIDTH 7
`define CTRL_RESET 8'h00
// Interrupt status and mask fields
`define IRQ_A 0
`define IRQ_B 1
`define IRQ_RESET 2'h0
// Values seen when a read meets a reload, and the counter reset value
`define CNT_UNDER_READ 16'hFFFF
`define CNT_OVER_READ 16'h0000
`define CNT_RESET 16'h0000
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

// ---- src/timer_pkg.sv ----
// Mode types shared by the timer unit and its two counter cores
// Assumes the constants header is compiled alongside
package timer_pkg;
   typedef enum logic [1:0] {A_TIMER, A_EVENT, A_ONESHOT, A_PWM} a_mode_e;
   typedef enum logic [1:0] {B_TIMER, B_EVENT, B_MEASURE, B_SPARE} b_mode_e;
endpackage : timer_pkg

// ---- src/timer_a_core.sv ----
// A-type counter: timer, event counter, one-shot and PWM
// Assumes event_rise is already synchronised to clk_sys
`timescale 1ns/1ps
`include "timer_consts.svh"
module timer_a_core (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire timer_pkg::a_mode_e mode,
   input wire logic start,
   input wire logic count_up,
   input wire logic event_rise,
   input wire logic load_stb,
   input wire logic [15:0] load_val,
   output logic [15:0] count_q,
   output logic reload_now,
   output logic under_now,
   output logic irq_set,
   output logic pulse_out_q
);
   logic [15:0] reload_q;
   logic start_q;
   logic run_q;
   // Mode decode and count qualifiers
   wire is_os = (mode == timer_pkg::A_ONESHOT);
   wire is_pwm = (mode == timer_pkg::A_PWM);
   wire is_ev = (mode == timer_pkg::A_EVENT);
   wire stopping = start_q & ~start;
   wire os_trig = is_os & start & ~start_q;
   wire pwm_go = is_pwm & start & ~start_q;
   wire os_abort = stopping & is_os & run_q;  // [R6]
   wire tick = is_ev ? event_rise : 1'b1;
   wire active = is_os ? run_q : start;
   wire up = is_ev & count_up;
   wire wrap = active & ~stopping & tick & (count_q == (up ? 16'hFFFF : 16'h0000));
   assign reload_now = wrap;
   assign under_now = ~up;
   // Abort of one-shot or PWM high phase raises the request [R7] [R11]
   assign irq_set = (wrap & ~(is_pwm & ~pulse_out_q)) | os_abort
      | (stopping & is_pwm & pulse_out_q);
   // Counter, reload and pin
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         count_q <= `CNT_RESET;
         reload_q <= `CNT_RESET;
         start_q <= 1'b0;
         run_q <= 1'b0;
         pulse_out_q <= 1'b0;
      end
      else
      begin
         start_q <= start;
         if (load_stb)
            reload_q <= load_val;
         if (load_stb & ~active)
            count_q <= load_val;  // [R4]
         else if (os_abort | os_trig | pwm_go | wrap)
            count_q <= reload_q;  // [R6]
         else if (active & tick)
            count_q <= up ? count_q + 16'h0001 : count_q - 16'h0001;
         if (os_trig)
            run_q <= 1'b1;
         else if (~start | (wrap & is_os))
            run_q <= 1'b0;
         if (os_trig | pwm_go)
            pulse_out_q <= 1'b1;
         else if ((stopping & (is_os | is_pwm)) | (wrap & is_os) | ~(is_os | is_pwm))
            pulse_out_q <= 1'b0;  // [R7] [R11] [R12]
         else if (wrap & is_pwm)
            pulse_out_q <= ~pulse_out_q;
      end
   end
endmodule : timer_a_core

// ---- src/timer_b_core.sv ----
// B-type counter: timer, event counter, pulse period or width measurement
// Assumes edge strobes are already synchronised to clk_sys
`timescale 1ns/1ps
`include "timer_consts.svh"
module timer_b_core (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire timer_pkg::b_mode_e mode,
   input wire logic start,
   input wire logic width_sel,
   input wire logic edge_rise,
   input wire logic edge_fall,
   input wire logic load_stb,
   input wire logic [15:0] load_val,
   output logic [15:0] count_view,
   output logic reload_now,
   output logic irq_set
);
   logic [15:0] cnt_q;
   logic [15:0] reload_q;
   logic start_q;
   logic first_q;
   wire is_meas = (mode == timer_pkg::B_MEASURE);
   wire tick = (mode == timer_pkg::B_EVENT) ? edge_rise : 1'b1;
   wire wrap = start & ~is_meas & tick & (cnt_q == 16'h0000);
   wire eff_edge = is_meas & start & (edge_rise | (width_sel & edge_fall));
   wire go = start & ~start_q;
   assign reload_now = wrap;
   // First edge after start gives no request [R15]
   assign irq_set = wrap | (eff_edge & ~first_q);
   // Measurement shows the captured value, other modes the live count
   assign count_view = is_meas ? reload_q : cnt_q;
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt_q <= `CNT_RESET;
         reload_q <= `CNT_RESET;
         start_q <= 1'b0;
         first_q <= 1'b0;
      end
      else
      begin
         start_q <= start;
         if (go)
            first_q <= 1'b1;
         else if (eff_edge)
            first_q <= 1'b0;
         if (eff_edge)
            reload_q <= cnt_q;  // [R15] First capture is meaningless
         else if (load_stb)
            reload_q <= load_val;
         if (load_stb & ~start)
            cnt_q <= load_val;
         else if ((go & is_meas) | eff_edge)
            cnt_q <= `CNT_RESET;
         else if (wrap)
            cnt_q <= reload_q;
         else if (start & tick)
            cnt_q <= is_meas ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
      end
   end
endmodule : timer_b_core

// ---- src/multi_mode_timer_unit.sv ----
// Timer unit top: AXI4-Lite registers, pin synchronisers, interrupt logic
// Assumes one clock clk_sys at 200 MHz and a master of the AXI4-Lite bus
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "timer_consts.svh"
// Summary of operation
// [R1] Counter reads return live count while counting
// [R2] Read at underflow reload returns all ones
// [R3] Read at up-count overflow reload returns zero
// [R4] Count written while halted reads back exactly
// [R5] Software rewrites free-run event counter after stop
// [R6] One-shot abort halts and reloads counter
// [R7] One-shot abort drives pin low, sets request
// [R8] Entering one-shot from timer/event sets request
// [R9] Entering PWM from timer/event sets request
// [R10] Software clears spurious requests after mode change
// [R11] PWM stop with pin high: low, request
// [R12] PWM stop with pin low: no change
// [R13] B-type read at reload returns all ones
// [R14] Measurement select change while counting sets request
// [R15] First measured edge: no request, junk capture
// [R16] Request bit sticky until software clears it
module multi_mode_timer_unit (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic a_event_pin,
   input wire logic b_event_pin,
   output logic timer_a_pulse_output_pin,
   output logic irq
);
   // ************************************************
   // Address decode
   // ************************************************
   function automatic logic is_reg(input logic [7:0] addr);
      is_reg = (addr == `OFS_CTRL) || (addr == `OFS_A_COUNT)
         || (addr == `OFS_B_COUNT) || (addr == `OFS_IRQ_STAT)
         || (addr == `OFS_IRQ_MASK) || (addr == `OFS_STATUS);
   endfunction : is_reg

   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic aw_have_q;
   logic w_have_q;
   logic [7:0] wr_addr_q;
   logic [31:0] wr_data_q;
   logic [3:0] wr_strb_q;
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic [7:0] ctrl_q;
   logic [1:0] stat_q;
   logic [1:0] mask_q;
   logic irq_q;
   logic [15:0] a_count;
   logic a_reload_now;
   logic a_under;
   logic a_irq;
   logic a_pin;
   logic [15:0] b_view;
   logic b_reload_now;
   logic b_irq;

   // ************************************************
   // Pin synchronisers
   // ************************************************
   // Three stages; a change is taken once stages two and three agree
   wire [1:0] pins = {b_event_pin, a_event_pin};
   logic [2:0] sync_q [2];
   logic [1:0] lvl_q;
   wire [1:0] pin_rise;
   wire [1:0] pin_fall;
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : g_sync
         wire agree = (sync_q[g][1] == sync_q[g][2]);
         assign pin_rise[g] = agree & sync_q[g][2] & ~lvl_q[g];
         assign pin_fall[g] = agree & ~sync_q[g][2] & lvl_q[g];
         always_ff @(posedge clk_sys or negedge reset_n)
         begin
            if (!reset_n)
            begin
               sync_q[g] <= 3'h0;
               lvl_q[g] <= 1'b0;
            end
            else
            begin
               sync_q[g] <= {sync_q[g][1:0], pins[g]};
               if (agree)
                  lvl_q[g] <= sync_q[g][2];
            end
         end
      end
   endgenerate

   // ************************************************
   // AXI4-Lite write channel
   // ************************************************
   // Address and data accepted in either order; one write in flight
   wire aw_take = awvalid & awready_q;
   wire w_take = wvalid & wready_q;
   wire wr_go = aw_have_q & w_have_q & ~bvalid_q;
   wire aw_have_d = aw_take | (aw_have_q & ~wr_go);
   wire w_have_d = w_take | (w_have_q & ~wr_go);
   wire bvalid_d = wr_go | (bvalid_q & ~bready);
   wire wr_hit = wr_go & is_reg(wr_addr_q);
   wire ctrl_wr = wr_go & (wr_addr_q == `OFS_CTRL) & wr_strb_q[0];
   // Counts load only on a full low half-word, avoiding torn values
   wire a_load = wr_go & (wr_addr_q == `OFS_A_COUNT) & (&wr_strb_q[1:0]);
   wire b_load = wr_go & (wr_addr_q == `OFS_B_COUNT) & (&wr_strb_q[1:0]);
   wire stat_wr = wr_go & (wr_addr_q == `OFS_IRQ_STAT) & wr_strb_q[0];
   wire mask_wr = wr_go & (wr_addr_q == `OFS_IRQ_MASK) & wr_strb_q[0];
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         wr_addr_q <= 8'h00;
         wr_data_q <= 32'h00000000;
         wr_strb_q <= 4'h0;
      end
      else
      begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         bvalid_q <= bvalid_d;
         awready_q <= ~aw_have_d & ~bvalid_d;
         wready_q <= ~w_have_d & ~bvalid_d;
         if (aw_take)
            wr_addr_q <= awaddr;
         if (w_take)
         begin
            wr_data_q <= wdata;
            wr_strb_q <= wstrb;
         end
         if (wr_go)
            bresp_q <= wr_hit ? `RESP_OKAY : `RESP_DECERR;
      end
   end

   // ************************************************
   // Control register and mode-change requests
   // ************************************************
   wire timer_pkg::a_mode_e a_mode = timer_pkg::a_mode_e'(ctrl_q[`CTRL_A_MODE]);
   wire timer_pkg::a_mode_e a_new = timer_pkg::a_mode_e'(wr_data_q[`CTRL_A_MODE]);
   wire timer_pkg::b_mode_e b_mode = timer_pkg::b_mode_e'(ctrl_q[`CTRL_B_MODE]);
   wire a_start = ctrl_q[`CTRL_A_START];
   wire b_start = ctrl_q[`CTRL_B_START];
   // Reset mode is timer, so selection after reset is covered too
   wire a_mode_irq = ctrl_wr
      & ((a_mode == timer_pkg::A_TIMER) | (a_mode == timer_pkg::A_EVENT))
      & ((a_new == timer_pkg::A_ONESHOT) | (a_new == timer_pkg::A_PWM));  // [R8] [R9]
   wire b_sel_irq = ctrl_wr & b_start & (b_mode == timer_pkg::B_MEASURE)
      & (wr_data_q[`CTRL_B_WIDTH] != ctrl_q[`CTRL_B_WIDTH]);  // [R14]
   wire a_stop_wr = ctrl_wr & a_start & ~wr_data_q[`CTRL_A_START];
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         ctrl_q <= `CTRL_RESET;
      else if (ctrl_wr)
         ctrl_q <= wr_data_q[7:0];
   end

   // ************************************************
   // Counter cores
   // ************************************************
   timer_a_core u_timer_a (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .mode(a_mode),
      .start(a_start),
      .count_up(ctrl_q[`CTRL_A_UP]),
      .event_rise(pin_rise[0]),
      .load_stb(a_load),
      .load_val(wr_data_q[15:0]),
      .count_q(a_count),
      .reload_now(a_reload_now),
      .under_now(a_under),
      .irq_set(a_irq),
      .pulse_out_q(a_pin)
   );
   timer_b_core u_timer_b (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .mode(b_mode),
      .start(b_start),
      .width_sel(ctrl_q[`CTRL_B_WIDTH]),
      .edge_rise(pin_rise[1]),
      .edge_fall(pin_fall[1]),
      .load_stb(b_load),
      .load_val(wr_data_q[15:0]),
      .count_view(b_view),
      .reload_now(b_reload_now),
      .irq_set(b_irq)
   );

   // ************************************************
   // Interrupt status and mask
   // ************************************************
   // Set wins over a same-cycle write-one clear
   wire [1:0] stat_set = {b_irq | b_sel_irq, a_irq | a_mode_irq};
   wire [1:0] stat_clr = stat_wr ? wr_data_q[1:0] : 2'h0;
   wire [1:0] stat_d = (stat_q & ~stat_clr) | stat_set;  // [R16]
   wire [1:0] mask_d = mask_wr ? wr_data_q[1:0] : mask_q;
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         stat_q <= `IRQ_RESET;
         mask_q <= `IRQ_RESET;
         irq_q <= 1'b0;
      end
      else
      begin
         stat_q <= stat_d;
         mask_q <= mask_d;
         irq_q <= |(stat_d & mask_d);
      end
   end

   // ************************************************
   // AXI4-Lite read channel
   // ************************************************
   // Count sampled in the address cycle: live value unless a reload lands
   wire [15:0] a_read = a_reload_now
      ? (a_under ? `CNT_UNDER_READ : `CNT_OVER_READ) : a_count;  // [R1] [R2] [R3]
   wire [15:0] b_read = b_reload_now ? `CNT_UNDER_READ : b_view;  // [R13]
   wire [31:0] rd_word =
      (araddr == `OFS_CTRL) ? {24'h000000, ctrl_q} :
      (araddr == `OFS_A_COUNT) ? {16'h0000, a_read} :
      (araddr == `OFS_B_COUNT) ? {16'h0000, b_read} :
      (araddr == `OFS_IRQ_STAT) ? {30'h00000000, stat_q} :
      (araddr == `OFS_IRQ_MASK) ? {30'h00000000, mask_q} :
      (araddr == `OFS_STATUS) ? {29'h00000000, lvl_q, a_pin} : 32'h00000000;
   wire ar_take = arvalid & arready_q;
   wire rvalid_d = ar_take | (rvalid_q & ~rready);
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `RESP_OKAY;
      end
      else
      begin
         rvalid_q <= rvalid_d;
         arready_q <= ~rvalid_d;
         if (ar_take)
         begin
            rdata_q <= rd_word;
            rresp_q <= is_reg(araddr) ? `RESP_OKAY : `RESP_DECERR;
         end
      end
   end

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign irq = irq_q;
   assign timer_a_pulse_output_pin = a_pin;

   // ************************************************
   // Assertions
   // ************************************************
   wire rd_a = ar_take & (araddr == `OFS_A_COUNT);
   AST_A_LIVE_READ: assert property (@(posedge clk_sys) disable iff (!reset_n)  // [R1]
      rd_a & ~a_reload_now |=> rdata[15:0] == $past(a_count))
      else $error("A count read not live");
   AST_A_UNDER_READ: assert property (@(posedge clk_sys) disable iff (!reset_n)  // [R2]
      rd_a & a_reload_now & a_under |=> rdata[15:0] == 16'hFFFF)
      else $error("A underflow read wrong");
   AST_A_OVER_READ: assert property (@(posedge clk_sys) disable iff (!reset_n)  // [R3]
      rd_a & a_reload_now & ~a_under |=> rdata[15:0] == 16'h0000)
      else $error("A overflow read wrong");
   AST_A_HALT_LOAD: assert property (@(posedge clk_sys) disable iff (!reset_n)  // [R4]
      a_load & ~a_start & (a_mode != timer_pkg::A_ONESHOT)
      |=> a_count == $past(wr_data_q[15:0]))
      else $error("Halted write not read back");
   AST_OS_ABORT: assert property (@(posedge clk_sys) disable iff (!reset_n)  // [R6] [R7]
      a_stop_wr & (a_mode == timer_pkg::A_ONESHOT) & a_pin & ~stat_wr
      |-> ##2 (~a_pin & stat_q[`IRQ_A]))
      else $error("One-shot abort wrong");
   AST_MODE_REQ: assert property (@(posedge clk_sys) disable iff (!reset_n)  // [R8] [R9]
      a_mode_irq |=> stat_q[`IRQ_A])
      else $error("Mode change request missing");
   AST_PWM_STOP_HI: assert property (@(posedge clk_sys) disable iff (!reset_n)  // [R11]
      a_stop_wr & (a_mode == timer_pkg::A_PWM) & a_pin & ~stat_wr
      |-> ##2 (~a_pin & stat_q[`IRQ_A]))
      else $error("PWM stop high wrong");
   // A wrap in the write cycle may raise the pin legally, so it is excluded
   AST_PWM_STOP_LO: assert property (@(posedge clk_sys) disable iff (!reset_n)  // [R12]
      a_stop_wr & (a_mode == timer_pkg::A_PWM) & ~a_pin & ~a_reload_now
      |-> ##1 ~a_pin ##1 ~a_pin)
      else $error("PWM stop low moved pin");
   AST_PWM_STOP_NOREQ: assert property (@(posedge clk_sys) disable iff (!reset_n)  // [R12]
      a_stop_wr & (a_mode == timer_pkg::A_PWM) & ~a_pin & ~a_reload_now & ~stat_q[`IRQ_A]
      |-> ##2 ~stat_q[`IRQ_A])
      else $error("PWM stop low raised request");
   AST_B_RELOAD_READ: assert property (@(posedge clk_sys) disable iff (!reset_n)  // [R13]
      ar_take & (araddr == `OFS_B_COUNT) & b_reload_now |=> rdata[15:0] == 16'hFFFF)
      else $error("B reload read wrong");
   // Reads away from the reload instant must show the live count, or the captured value in measurement mode
   AST_B_LIVE_READ: assert property (@(posedge clk_sys) disable iff (!reset_n)  // [R13]
      ar_take & (araddr == `OFS_B_COUNT) & ~b_reload_now |=> rdata[15:0] == $past(b_view))
      else $error("B count read not live");
   AST_B_SEL_REQ: assert property (@(posedge clk_sys) disable iff (!reset_n)  // [R14]
      b_sel_irq |=> stat_q[`IRQ_B])
      else $error("Select change request missing");
   AST_STICKY: assert property (@(posedge clk_sys) disable iff (!reset_n)  // [R16]
      stat_q[`IRQ_A] & ~stat_clr[`IRQ_A] |=> stat_q[`IRQ_A])
      else $error("Request bit dropped");
endmodule : multi_mode_timer_unit

// ---- verif/tb_top.sv ----
// Self-checking bench for the multi-mode timer unit, driven over AXI4-Lite
// Assumes timer_consts.svh on the include path and a 200 MHz clk_sys
`timescale 1ns/1ps
`include "timer_consts.svh"
`define CHK(g, e) chk(32'(g), 32'(e))
module tb_top;
   logic clk_sys, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, a_event_pin, b_event_pin, pin, irq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd_data;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rd_resp, wr_resp;
   int err_count = 0;
   int checks = 0;
   multi_mode_timer_unit multi_mode_timer_unit_inst (.clk_sys(clk_sys), .reset_n(reset_n),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .a_event_pin(a_event_pin), .b_event_pin(b_event_pin),
      .timer_a_pulse_output_pin(pin), .irq(irq));
   // ****************************************
   // Clock, watchdog and shared tasks
   // ****************************************
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // Whole run is about a thousand cycles; generous margin
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      test_done();
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task axi_write(input logic [7:0] a, input logic [31:0] d);
      bit aw_ok, w_ok;
      aw_ok = 0;
      w_ok = 0;
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hF;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // Hold each channel until its own ready edge, then the answer
      for (int n = 0; n < 50; n++)
      begin
         @(posedge clk_sys);
         if (awvalid && awready)
         begin
            awvalid <= 1'b0;
            aw_ok = 1;
         end
         if (wvalid && wready)
         begin
            wvalid <= 1'b0;
            w_ok = 1;
         end
         // Ready stays high between writes, so no release races the next call
         if (bvalid === 1'b1 && aw_ok && w_ok)
         begin
            wr_resp = bresp;
            return;
         end
      end
      `CHK(0, 1); // bus hang
   endtask : axi_write
   task axi_read(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 50; n++)
      begin
         @(posedge clk_sys);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid === 1'b1 && !arvalid)
         begin
            rd_data = rdata;
            rd_resp = rresp;
            return;
         end
      end
      `CHK(0, 1); // bus hang
   endtask : axi_read
   task pulse(input bit b);
      if (b) b_event_pin <= 1'b1; else a_event_pin <= 1'b1;
      repeat (8) @(posedge clk_sys);
      if (b) b_event_pin <= 1'b0; else a_event_pin <= 1'b0;
      repeat (8) @(posedge clk_sys);
   endtask : pulse
   // Reads counter repeatedly with varied spacing to meet a reload instant
   task hunt(input logic [7:0] ofs, input logic [7:0] ctrl);
      bit seen;
      seen = 0;
      axi_write(`OFS_CTRL, 32'h0);
      axi_write(ofs, 32'h3);
      axi_write(`OFS_CTRL, {24'h0, ctrl});
      for (int k = 0; k < 24; k++)
      begin
         repeat (k % 5) @(posedge clk_sys);
         axi_read(ofs);
         if (rd_data === 32'h0000FFFF) seen = 1;
         else `CHK(rd_data <= 32'h3, 1);
      end
      `CHK(seen, 1);
   endtask : hunt
   // ****************************************
   // Scenarios
   // ****************************************
   task t_regs;
      axi_read(`OFS_CTRL); `CHK(rd_data, `CTRL_RESET);
      axi_read(`OFS_IRQ_STAT); `CHK(rd_data, `IRQ_RESET);
      axi_read(`OFS_IRQ_MASK); `CHK(rd_data, `IRQ_RESET);
      axi_read(8'h3C); `CHK(rd_resp, `RESP_DECERR);
      axi_write(8'h3C, 32'h1); `CHK(wr_resp, `RESP_DECERR);
      axi_write(`OFS_A_COUNT, 32'h1234); `CHK(wr_resp, `RESP_OKAY);
      axi_read(`OFS_A_COUNT); `CHK(rd_data, 32'h1234);
      $display("test regs done");
   endtask : t_regs
   task t_live;
      logic [31:0] v1;
      bit hit0;
      axi_write(`OFS_CTRL, 32'h1);
      axi_read(`OFS_A_COUNT);
      v1 = rd_data;
      axi_read(`OFS_A_COUNT);
      `CHK(v1 < 32'h1234 && rd_data < v1, 1);
      axi_write(`OFS_CTRL, 32'h0);
      axi_write(`OFS_A_COUNT, 32'h5);
      axi_write(`OFS_CTRL, 32'h3);
      repeat (3) pulse(0);
      axi_read(`OFS_A_COUNT); `CHK(rd_data, 32'h2);
      // Up-count with all-ones reload wraps on every edge; one delay meets it
      axi_write(`OFS_CTRL, 32'h0);
      axi_write(`OFS_A_COUNT, 32'hFFFF);
      axi_write(`OFS_CTRL, 32'hB);
      hit0 = 0;
      for (int d = 0; d < 6; d++)
      begin
         a_event_pin <= 1'b1;
         repeat (d) @(posedge clk_sys);
         axi_read(`OFS_A_COUNT);
         if (rd_data === 32'h0) hit0 = 1;
         else `CHK(rd_data, 32'hFFFF);
         a_event_pin <= 1'b0;
         repeat (8) @(posedge clk_sys);
      end
      `CHK(hit0, 1);
      hunt(`OFS_A_COUNT, 8'h01);
      hunt(`OFS_B_COUNT, 8'h10);
      $display("test live done");
   endtask : t_live
   task t_irq;
      axi_write(`OFS_CTRL, 32'h1);
      axi_write(`OFS_IRQ_MASK, 32'h0);
      repeat (3) @(posedge clk_sys);
      `CHK(irq, 0);
      axi_write(`OFS_IRQ_MASK, 32'h1);
      repeat (3) @(posedge clk_sys);
      `CHK(irq, 1);
      axi_write(`OFS_CTRL, 32'h0);
      axi_write(`OFS_IRQ_STAT, 32'h3);
      repeat (3) @(posedge clk_sys);
      `CHK(irq, 0);
      axi_read(`OFS_IRQ_STAT); `CHK(rd_data, 0);
      $display("test irq done");
   endtask : t_irq
   // Entering one-shot or PWM from timer or event mode raises a request
   task t_mode(input logic [31:0] from_m, input logic [31:0] to_m);
      axi_write(`OFS_CTRL, from_m);
      axi_write(`OFS_IRQ_STAT, 32'h3);
      axi_read(`OFS_IRQ_STAT); `CHK(rd_data[`IRQ_A], 0);
      axi_write(`OFS_CTRL, to_m);
      repeat (10) @(posedge clk_sys);
      axi_read(`OFS_IRQ_STAT); `CHK(rd_data[`IRQ_A], 1);
      repeat (20) @(posedge clk_sys);
      axi_read(`OFS_IRQ_STAT); `CHK(rd_data[`IRQ_A], 1);
      axi_write(`OFS_IRQ_STAT, 32'h1);
      axi_read(`OFS_IRQ_STAT); `CHK(rd_data[`IRQ_A], 0);
   endtask : t_mode
   // Stop a running one-shot (run=5) or PWM (run=7) while the pin is high
   task t_stop_high(input logic [31:0] run);
      axi_write(`OFS_CTRL, 32'h0);
      axi_write(`OFS_A_COUNT, 32'h200);
      axi_write(`OFS_CTRL, run);
      repeat (6) @(posedge clk_sys);
      `CHK(pin, 1);
      axi_write(`OFS_IRQ_STAT, 32'h1);
      axi_write(`OFS_CTRL, run & 32'h6);
      repeat (4) @(posedge clk_sys);
      `CHK(pin, 0);
      axi_read(`OFS_IRQ_STAT); `CHK(rd_data[`IRQ_A], 1);
      axi_read(`OFS_A_COUNT); if (run == 5) `CHK(rd_data, 32'h200);
      $display("test stop high done");
   endtask : t_stop_high
   task t_pwm_low;
      int n;
      axi_write(`OFS_CTRL, 32'h0);
      axi_write(`OFS_A_COUNT, 32'h40);
      axi_write(`OFS_CTRL, 32'h7);
      n = 0;
      // Low phase lasts a full period, so stop lands well inside it
      while (pin !== 1'b0 || n < 5)
      begin
         @(posedge clk_sys);
         n++;
         if (n > 400) break;
      end
      axi_write(`OFS_IRQ_STAT, 32'h1);
      axi_write(`OFS_CTRL, 32'h6);
      repeat (6) @(posedge clk_sys);
      `CHK(pin, 0);
      axi_read(`OFS_IRQ_STAT); `CHK(rd_data[`IRQ_A], 0);
      $display("test pwm low done");
   endtask : t_pwm_low
   task t_measure;
      axi_write(`OFS_CTRL, 32'h0);
      axi_write(`OFS_CTRL, 32'h50);
      axi_write(`OFS_IRQ_STAT, 32'h3);
      pulse(1);
      axi_read(`OFS_IRQ_STAT); `CHK(rd_data[`IRQ_B], 0);
      pulse(1);
      axi_read(`OFS_IRQ_STAT); `CHK(rd_data[`IRQ_B], 1);
      axi_write(`OFS_IRQ_STAT, 32'h2);
      axi_write(`OFS_CTRL, 32'hD0);
      repeat (4) @(posedge clk_sys);
      axi_read(`OFS_IRQ_STAT); `CHK(rd_data[`IRQ_B], 1);
      $display("test measure done");
   endtask : t_measure
   task test_done;
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      reset_n = 1'b0; awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0;
      wvalid = 1'b0; bready = 1'b0; araddr = 8'h00; arvalid = 1'b0; rready = 1'b0;
      a_event_pin = 1'b0; b_event_pin = 1'b0;
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      t_regs();
      t_live();
      t_irq();
      t_mode(32'h0, 32'h4);
      t_mode(32'h2, 32'h6);
      t_mode(32'h2, 32'h4);
      t_mode(32'h0, 32'h6);
      $display("test modes done");
      t_stop_high(32'h5);
      t_stop_high(32'h7);
      t_pwm_low();
      t_measure();
      test_done();
   end
endmodule : tb_top
